// ==== pmc_far_model.sv ====
// Far side model: CPU instruction pulses, interrupt level, NMI, reset input
// and fast wake pins. Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none

module pmc_far_model
  import pmc_pkg::*;
(
  // Clock
  input  wire logic                 clk_sys,
  // CPU side
  output logic                      idle_req,
  output logic                      power_down_instruction_req,
  output logic                      end_of_init_instruction_req,
  output logic                      irq_req,
  // Pins
  output logic [FAST_PINS-1:0]      fast_irq_pin,
  output logic                      nmi_pin_n,
  output logic                      ext_reset_in_n
);
  // ==========================================================
  // Idle levels from time zero: no request, pins inactive
  initial begin
    idle_req       = 1'b0;
    power_down_instruction_req      = 1'b0;
    end_of_init_instruction_req      = 1'b0;
    irq_req        = 1'b0;
    fast_irq_pin   = '0;
    nmi_pin_n      = 1'b1;
    ext_reset_in_n = 1'b1;
  end

  // ==========================================================
  // One-cycle instruction pulse: 0 idle, 1 power down, 2 end of init
  task automatic pulse(input int kind);
    @(posedge clk_sys);
    idle_req  <= (kind == 0);
    power_down_instruction_req <= (kind == 1);
    end_of_init_instruction_req <= (kind == 2);
    @(posedge clk_sys);
    idle_req  <= 1'b0;
    power_down_instruction_req <= 1'b0;
    end_of_init_instruction_req <= 1'b0;
  endtask : pulse

  // Line levels, held at least the least wake time so the synchroniser sees them
  task automatic lines(input logic [FAST_PINS-1:0] pins, input logic nmi_n, input logic rst_n, input logic irq);
    @(posedge clk_sys);
    fast_irq_pin   <= pins;
    nmi_pin_n      <= nmi_n;
    ext_reset_in_n <= rst_n;
    irq_req        <= irq;
    repeat (MIN_WAKE_CYC) @(posedge clk_sys);
  endtask : lines
endmodule : pmc_far_model

`default_nettype wire

// ==== pmc_pkg.sv ====
// Constants, types and register map of the power mode controller.
// Assumes one 125 MHz system clock and a plain register port.
//
// Notes on behaviour
// R1: Idle halts CPU, peripherals keep running.
// R2: Any reset or interrupt ends idle.
// R3: After idle wake, CPU serves interrupt, resumes.
// R4: Power down stops CPU and all peripherals.
// R5: Pending external bus transactions finish before entry.
// R6: Power down gates clocks, stops watchdog, keeps RAM.
// R7: Running RTC keeps main oscillator on in power down.
// R8: Misc bit 3 switches regulator off in power down.
// R9: Misc bit 4 routes port 7 onto shared pins.
// R10: Misc bit 2 selects undivided CAN clock.
// R11: Software keeps CAN divider above 40 MHz CPU.
// R12: Misc bit 1 maps both CANs on first pair.
// R13: Disabled first CAN keeps second on own pins.
// R14: Config bit 5 picks protected or interruptible variant.
// R15: Protected entry only while NMI pin is low.
// R16: Protected power down ends only by reset input.
// R17: Interruptible entry needs enabled pins all inactive.
// R18: Interruptible wake: pin, RTC, CAN, I2C, reset.
// R19: Config register locked after end of initialisation.
// R20: Two-bit edge field per fast interrupt pin.
// R21: Wake source holds pin at least 40 ns.
// R22: CPU pulses requests, controller returns wake indication.

package pmc_pkg;

  // ==========================================================
  // Register map
  localparam logic [15:0] SYSCFG_ADDR  = 16'hff12;  // System configuration
  localparam logic [15:0] MISC_ADDR    = 16'hf0c2;  // Misc extra control
  localparam logic [15:0] STAT_ADDR    = 16'hf0c4;  // Controller status
  localparam logic [15:0] SYSCFG_RST   = 16'h0000;  // Value after reset
  localparam logic [15:0] MISC_RST     = 16'h0000;  // Value after reset
  localparam logic [15:0] SYSCFG_WMASK = 16'h1fff;  // Bits 15..13 reserved
  localparam logic [15:0] MISC_WMASK   = 16'h001e;  // Bits 4..1 only

  // ==========================================================
  // Field positions
  localparam int PD_VARIANT_BIT = 5;  // Config: interruptible variant
  localparam int PORT_REMAP_BIT = 4;  // Misc: port remap select
  localparam int REG_OFF_BIT    = 3;  // Misc: main regulator off
  localparam int CAN_UNDIV_BIT  = 2;  // Misc: undivided CAN clock
  localparam int CAN_PAR_BIT    = 1;  // Misc: parallel CAN mapping

  // ==========================================================
  // Wake pin edge field codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;  // Pin ignored
  localparam logic [1:0] EDGE_HIGH = 2'h1;  // High active
  localparam logic [1:0] EDGE_LOW  = 2'h2;  // Low active
  localparam logic [1:0] EDGE_ANY  = 2'h3;  // Any level change

  // ==========================================================
  // Pins and synchroniser
  localparam int          FAST_PINS = 8;           // Fast interrupt pins
  localparam int          SYNC_W    = 10;          // Pins, NMI, reset
  localparam logic [9:0]  SYNC_RST  = 10'h300;     // NMI and reset idle high

  // ==========================================================
  // Timing
  localparam int CLK_MHZ      = 125;  // System clock rate
  localparam int MIN_WAKE_NS  = 40;   // Least wake pin assertion
  localparam int MIN_WAKE_CYC = (MIN_WAKE_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Wake source codes
  localparam logic [2:0] WK_NONE  = 3'h0;
  localparam logic [2:0] WK_RESET = 3'h1;
  localparam logic [2:0] WK_IRQ   = 3'h2;
  localparam logic [2:0] WK_PIN   = 3'h3;
  localparam logic [2:0] WK_RTC   = 3'h4;
  localparam logic [2:0] WK_SER   = 3'h5;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    PMC_RUN        = 3'h0,
    PMC_DRAIN_IDLE = 3'h1,
    PMC_DRAIN_PD   = 3'h2,
    PMC_IDLE       = 3'h3,
    PMC_PDOWN      = 3'h4
  } pmc_mode_e;

  typedef struct packed {
    logic [15:0] addr;   // Register address
    logic [15:0] wdata;  // Write data
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
  } pmc_regreq_s;

  typedef struct packed {
    logic cpu_run;       // CPU may execute
    logic periph_clk_en; // Peripheral clocks on
    logic wdt_run;       // Watchdog counts
    logic osc_run;       // Main oscillator on
    logic main_reg_off;  // Main regulator off
    logic can_clk_en;    // CAN clock strobe
  } pmc_clkctl_s;

  typedef struct packed {
    logic port7_sel;     // Port 7 on shared pins
    logic can2_on_can1;  // Both CANs on first pair
  } pmc_pinmap_s;

endpackage : pmc_pkg

// ==== pmc_power_mode_controller.sv ====
// Power mode controller: idle, power down, wake and misc control.
// Assumes CPU request pulses on CLK_SYS and pins from outside the
// clock domain; the edge field word comes from on-chip logic.
`timescale 1ns/1ps
`default_nettype none

module pmc_power_mode_controller
  import pmc_pkg::*;
(
  // Clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESET_N,
  // Register port
  input  wire pmc_regreq_s          REG_REQ,
  output logic [15:0]               REG_RDATA,
  // CPU requests and answer
  input  wire logic                 IDLE_REQ,
  input  wire logic                 POWER_DOWN_INSTRUCTION_REQ,
  input  wire logic                 END_OF_INIT_INSTRUCTION_REQ,
  input  wire logic                 IRQ_REQ,
  output logic                      WAKE,
  // External bus state
  input  wire logic                 BUS_BUSY,
  // Pins
  input  wire logic [FAST_PINS-1:0] FAST_IRQ_PIN,
  input  wire logic                 NMI_PIN_N,
  input  wire logic                 EXT_RESET_IN_N,
  // Wake sources and peripheral state
  input  wire logic [15:0]          WAKE_EDGE_CFG,
  input  wire logic                 RTC_RUN,
  input  wire logic                 RTC_IRQ,
  input  wire logic                 CAN_IRQ,
  input  wire logic                 I2C_IRQ,
  input  wire logic                 FIRST_CAN_EN,
  input  wire logic                 SECOND_CAN_EN,
  // Controls
  output pmc_clkctl_s               CLK_CTL,
  output pmc_pinmap_s               PIN_MAP
);

  // ==========================================================
  // State
  typedef struct packed {
    pmc_mode_e            mode;      // Operating mode
    logic [SYNC_W-1:0]    s1;        // Sync stage one
    logic [SYNC_W-1:0]    s2;        // Sync stage two
    logic [SYNC_W-1:0]    s3;        // Sync stage three
    logic [SYNC_W-1:0]    stable;    // Agreed pin levels
    logic [FAST_PINS-1:0] snap;      // Pin levels at entry
    logic [15:0]          syscfg;    // System configuration
    logic [15:0]          misc;      // Misc extra control
    logic                 end_of_init_instruction_done;// Config locked
    logic [2:0]           src;       // Last wake source
    logic                 wake;      // Wake pulse
    logic                 can_div;   // CAN clock divider
    logic                 map2;      // Second CAN remapped
    logic [15:0]          rdata;     // Read data
  } pmc_state_s;

  pmc_state_s q_r;   // Registered state
  pmc_state_s q_nxt; // Next state

  // Decoded pins and wake terms
  logic [FAST_PINS-1:0] pins;      // Filtered pin levels
  logic                 nmi_n;     // Filtered NMI
  logic                 ext_rst;   // Reset input asserted
  logic                 variant;   // Interruptible variant
  logic [FAST_PINS-1:0] pin_act;   // Pin at wake level
  logic [FAST_PINS-1:0] pin_blk;   // Pin forbids entry
  logic                 pd_ok;     // Entry allowed
  logic                 wake_any;  // Interruptible wake
  logic [2:0]           wake_src;  // Its source code
  logic [1:0]           fld;       // Edge field of a pin

  assign pins    = q_r.stable[FAST_PINS-1:0];
  assign nmi_n   = q_r.stable[FAST_PINS];
  assign ext_rst = ~q_r.stable[FAST_PINS+1];
  assign variant = q_r.syscfg[PD_VARIANT_BIT];  // [R14]

  // ==========================================================
  // Wake pin decode
  // Any-change pins compare against the snapshot taken at entry,
  // so they never block entry but wake on the first change.
  always_comb begin
    fld     = EDGE_OFF;
    pin_act = '0;
    pin_blk = '0;
    for (int i = 0; i < FAST_PINS; i++) begin
      fld = WAKE_EDGE_CFG[2*i +: 2];
      case (fld)  // [R20]
        EDGE_HIGH: begin
          pin_act[i] = pins[i];
          pin_blk[i] = pins[i];
        end
        EDGE_LOW: begin
          pin_act[i] = ~pins[i];
          pin_blk[i] = ~pins[i];
        end
        EDGE_ANY: begin
          pin_act[i] = pins[i] ^ q_r.snap[i];
          pin_blk[i] = 1'b0;
        end
        default: begin
          pin_act[i] = 1'b0;
          pin_blk[i] = 1'b0;
        end
      endcase
    end
  end

  // Entry check per variant
  assign pd_ok = variant ? ~|pin_blk  // [R17]
                         : ~nmi_n;    // [R15]

  // ==========================================================
  // Wake source priority in interruptible power down
  always_comb begin
    wake_any = 1'b1;
    wake_src = WK_PIN;
    if (|pin_act) begin  // [R18]
      wake_src = WK_PIN;
    end else if (RTC_IRQ && RTC_RUN) begin
      wake_src = WK_RTC;
    end else if (CAN_IRQ || I2C_IRQ) begin
      wake_src = WK_SER;
    end else begin
      wake_any = 1'b0;
      wake_src = WK_NONE;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    q_nxt      = q_r;
    q_nxt.wake = 1'b0;

    // Three-stage synchroniser; a level counts once s2 and s3 agree
    q_nxt.s1     = {EXT_RESET_IN_N, NMI_PIN_N, FAST_IRQ_PIN};
    q_nxt.s2     = q_r.s1;
    q_nxt.s3     = q_r.s2;
    // Agreeing stages load their level; a disagreement keeps the old one
    q_nxt.stable = (q_r.s2 & q_r.s3) | (q_r.stable & (q_r.s2 ^ q_r.s3));

    // Lock on end of initialisation; nothing unlocks but reset
    if (END_OF_INIT_INSTRUCTION_REQ) begin
      q_nxt.end_of_init_instruction_done = 1'b1;
    end

    // Register writes
    if (REG_REQ.wr) begin
      if (REG_REQ.addr == SYSCFG_ADDR && !q_r.end_of_init_instruction_done) begin  // [R19]
        q_nxt.syscfg = REG_REQ.wdata & SYSCFG_WMASK;
      end
      if (REG_REQ.addr == MISC_ADDR) begin
        q_nxt.misc = REG_REQ.wdata & MISC_WMASK;
      end
    end

    // Register reads; data stand only in the cycle after the strobe
    q_nxt.rdata = 16'h0000;
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        SYSCFG_ADDR: q_nxt.rdata = q_r.syscfg;
        MISC_ADDR:   q_nxt.rdata = q_r.misc;
        STAT_ADDR:   q_nxt.rdata = {8'h00, q_r.end_of_init_instruction_done, q_r.src,
                                    1'b0, q_r.mode};
        default:     q_nxt.rdata = 16'h0000;  // Unmapped reads zero
      endcase
    end

    // Divide-by-two strobe runs free; undivided overrides it
    q_nxt.can_div = ~q_r.can_div;

    // Parallel CAN mapping needs both controllers on
    q_nxt.map2 = q_r.misc[CAN_PAR_BIT]  // [R12]
               & FIRST_CAN_EN           // [R13]
               & SECOND_CAN_EN;

    // Mode sequencing
    if (ext_rst) begin
      // Reset input ends every low power mode
      q_nxt.mode = PMC_RUN;  // [R2] [R16]
      if (q_r.mode != PMC_RUN) begin
        q_nxt.wake = 1'b1;
        q_nxt.src  = WK_RESET;
      end
    end else begin
      case (q_r.mode)
        PMC_RUN: begin
          if (IDLE_REQ) begin  // [R22]
            q_nxt.mode = PMC_DRAIN_IDLE;
          end else if (POWER_DOWN_INSTRUCTION_REQ && pd_ok) begin  // [R15] [R17]
            q_nxt.mode = PMC_DRAIN_PD;
          end
        end
        PMC_DRAIN_IDLE: begin
          // Wait for the external bus to go quiet
          if (!BUS_BUSY) begin  // [R5]
            q_nxt.mode = PMC_IDLE;
          end
        end
        PMC_DRAIN_PD: begin
          if (!BUS_BUSY) begin  // [R5]
            q_nxt.mode = PMC_PDOWN;
            q_nxt.snap = pins;
          end
        end
        PMC_IDLE: begin
          // CPU resumes and serves the pending interrupt
          if (IRQ_REQ) begin  // [R2] [R3]
            q_nxt.mode = PMC_RUN;
            q_nxt.wake = 1'b1;  // [R22]
            q_nxt.src  = WK_IRQ;
          end
        end
        PMC_PDOWN: begin
          // Protected variant waits for the reset input only
          if (variant && wake_any) begin  // [R16] [R18]
            q_nxt.mode = PMC_RUN;
            q_nxt.wake = 1'b1;  // [R22]
            q_nxt.src  = wake_src;
          end
        end
        default: begin
          q_nxt.mode = PMC_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      q_r            <= '0;
      q_r.mode       <= PMC_RUN;
      q_r.s1         <= SYNC_RST;
      q_r.s2         <= SYNC_RST;
      q_r.s3         <= SYNC_RST;
      q_r.stable     <= SYNC_RST;
      q_r.syscfg     <= SYSCFG_RST;
      q_r.misc       <= MISC_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // RAM supply is never touched here, so contents survive power down.
  assign CLK_CTL.cpu_run       = (q_r.mode == PMC_RUN);      // [R1]
  assign CLK_CTL.periph_clk_en = (q_r.mode != PMC_PDOWN);    // [R1] [R4] [R6]
  assign CLK_CTL.wdt_run       = (q_r.mode != PMC_PDOWN);    // [R6]
  assign CLK_CTL.osc_run       = (q_r.mode != PMC_PDOWN) | RTC_RUN;  // [R7]
  assign CLK_CTL.main_reg_off  = (q_r.mode == PMC_PDOWN)
                               & q_r.misc[REG_OFF_BIT];      // [R8]
  assign CLK_CTL.can_clk_en    = (q_r.mode != PMC_PDOWN)
                               & (q_r.misc[CAN_UNDIV_BIT] | q_r.can_div);  // [R10]
  assign PIN_MAP.port7_sel     = q_r.misc[PORT_REMAP_BIT];   // [R9]
  assign PIN_MAP.can2_on_can1  = q_r.map2;
  assign WAKE                  = q_r.wake;
  assign REG_RDATA             = q_r.rdata;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  sequence s_idle_irq;
    (q_r.mode == PMC_IDLE) && !ext_rst && IRQ_REQ;
  endsequence

  sequence s_back_running;
    (q_r.mode == PMC_RUN) && WAKE && (q_r.src == WK_IRQ);
  endsequence

  sequence s_prot_refused;
    (q_r.mode == PMC_RUN) && POWER_DOWN_INSTRUCTION_REQ && !IDLE_REQ && !variant
      && nmi_n && !ext_rst;
  endsequence

  AST_IDLE_HALT: assert property (  // [R1]
    (q_r.mode == PMC_IDLE) |-> !CLK_CTL.cpu_run && CLK_CTL.periph_clk_en)
    else $error("idle must halt CPU and keep peripherals");

  AST_IDLE_EXIT: assert property (  // [R2]
    s_idle_irq |=> s_back_running ##1 !WAKE)
    else $error("interrupt did not end idle with one wake pulse");

  AST_PD_STOP: assert property (  // [R4]
    (q_r.mode == PMC_PDOWN) |-> !CLK_CTL.cpu_run && !CLK_CTL.periph_clk_en
      && !CLK_CTL.wdt_run && !CLK_CTL.can_clk_en)
    else $error("power down left a clock running");

  AST_DRAIN: assert property (  // [R5]
    (q_r.mode == PMC_DRAIN_PD) && BUS_BUSY && !ext_rst |=> (q_r.mode == PMC_DRAIN_PD))
    else $error("power down entered with bus busy");

  AST_RTC_OSC: assert property (  // [R7]
    (q_r.mode == PMC_PDOWN) |-> (CLK_CTL.osc_run == RTC_RUN))
    else $error("oscillator state wrong in power down");

  AST_REG_OFF: assert property (  // [R8]
    $rose(q_r.mode == PMC_PDOWN) |-> (CLK_CTL.main_reg_off == q_r.misc[REG_OFF_BIT]))
    else $error("regulator off not applied at entry");

  AST_PROT_NMI: assert property (  // [R15]
    s_prot_refused |=> (q_r.mode == PMC_RUN) ##1 (q_r.mode == PMC_RUN))
    else $error("protected power down entered with NMI high");

  AST_PROT_HOLD: assert property (  // [R16]
    (q_r.mode == PMC_PDOWN) && !variant && !ext_rst |=> (q_r.mode == PMC_PDOWN) && !WAKE)
    else $error("protected power down left without reset");

  AST_CFG_LOCK: assert property (  // [R19]
    q_r.end_of_init_instruction_done && REG_REQ.wr && (REG_REQ.addr == SYSCFG_ADDR) |=> $stable(q_r.syscfg))
    else $error("config written after lock");

  AST_CAN_MAP: assert property (  // [R13]
    !FIRST_CAN_EN |=> !PIN_MAP.can2_on_can1)
    else $error("second CAN moved while first disabled");

  AST_WAKE_PULSE: assert property (  // [R22]
    WAKE |-> (q_r.mode == PMC_RUN) ##1 !WAKE)
    else $error("wake indication not a single pulse in run");

  // A pin level counts only once stages two and three agree; a sticky
  // level here would hide every falling pin and NMI edge.
  AST_SYNC_FOLLOW: assert property (  // [R18]
    (q_r.s2 == q_r.s3) |=> (q_r.stable == $past(q_r.s3)))
    else $error("synchroniser did not follow agreeing stages");

  AST_INT_WAKE: assert property (  // [R18]
    (q_r.mode == PMC_PDOWN) && variant && !ext_rst && wake_any |=> (q_r.mode == PMC_RUN) && WAKE)
    else $error("interruptible power down missed a wake source");

  // Divided CAN clock is a strobe every other cycle while misc holds still
  AST_CAN_DIV: assert property (  // [R10]
    CLK_CTL.can_clk_en && !q_r.misc[CAN_UNDIV_BIT] && !REG_REQ.wr |=> !CLK_CTL.can_clk_en)
    else $error("divided CAN clock strobe held two cycles");

endmodule : pmc_power_mode_controller

`default_nettype wire

// ==== tb.sv ====
// Self-checking bench of the power mode controller.
// Assumes the far side model drives CPU pulses and pins; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pmc_pkg::*;

  // ==========================================================
  // Register rows: address, data written, value read back
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } pmc_row_s;

  pmc_row_s rows [6] = '{
    '{MISC_ADDR,   16'hffff, 16'hffff & MISC_WMASK},
    '{MISC_ADDR,   16'h0000, 16'h0000},
    '{SYSCFG_ADDR, 16'hffff, 16'hffff & SYSCFG_WMASK},
    '{SYSCFG_ADDR, 16'h0000, 16'h0000},
    '{16'h1234,    16'ha5a5, 16'h0000},  // Unmapped place
    '{STAT_ADDR,   16'hffff, 16'h0000}   // Read-only status
  };

  logic                 clk_sys;   // System clock
  logic                 reset_n;   // Async reset
  pmc_regreq_s          req;       // Register request
  logic [15:0]          rdata;     // Read data
  logic                 wake;      // Wake pulse
  logic                 bus_busy;  // Bus transaction pending
  logic [15:0]          edge_cfg;  // Wake pin edge fields
  logic                 rtc_run;
  logic                 rtc_irq;
  logic                 can_irq;
  logic                 i2c_irq;
  logic                 can1_en;
  logic                 can2_en;
  pmc_clkctl_s          clk_ctl;
  pmc_pinmap_s          pin_map;
  logic                 idle_req;
  logic                 power_down_instruction_req;
  logic                 end_of_init_instruction_req;
  logic                 irq_req;
  logic [FAST_PINS-1:0] pins;
  logic                 nmi_n;
  logic                 rst_in_n;
  int                   errors;
  int                   comparisons;
  int                   wake_cnt;  // Wake pulses seen
  int                   c0;
  logic                 a;

  pmc_power_mode_controller dut_u (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .REG_REQ(req), .REG_RDATA(rdata),
    .IDLE_REQ(idle_req), .POWER_DOWN_INSTRUCTION_REQ(power_down_instruction_req), .END_OF_INIT_INSTRUCTION_REQ(end_of_init_instruction_req), .IRQ_REQ(irq_req),
    .WAKE(wake), .BUS_BUSY(bus_busy), .FAST_IRQ_PIN(pins), .NMI_PIN_N(nmi_n),
    .EXT_RESET_IN_N(rst_in_n), .WAKE_EDGE_CFG(edge_cfg), .RTC_RUN(rtc_run),
    .RTC_IRQ(rtc_irq), .CAN_IRQ(can_irq), .I2C_IRQ(i2c_irq), .FIRST_CAN_EN(can1_en),
    .SECOND_CAN_EN(can2_en), .CLK_CTL(clk_ctl), .PIN_MAP(pin_map)
  );

  pmc_far_model far_u (
    .clk_sys(clk_sys), .idle_req(idle_req), .power_down_instruction_req(power_down_instruction_req), .end_of_init_instruction_req(end_of_init_instruction_req),
    .irq_req(irq_req), .fast_irq_pin(pins), .nmi_pin_n(nmi_n), .ext_reset_in_n(rst_in_n)
  );

  // ==========================================================
  // 125 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Counts wake pulses so a pulse inside a held line is not missed
  always @(posedge clk_sys) begin
    if (wake === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
    end
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(posedge clk_sys);
    req.wr    <= 1'b1;
    req.addr  <= addr;
    req.wdata <= data;
    @(posedge clk_sys);
    req.wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] addr, input logic [15:0] exp, input string msg);
    @(posedge clk_sys);
    req.rd   <= 1'b1;
    req.addr <= addr;
    @(posedge clk_sys);
    req.rd   <= 1'b0;
    #1 chk(rdata, exp, msg);
  endtask : rchk

  // One more edge lets a wake pulse launched at the caller's edge be counted
  task automatic wake_chk(input string msg);
    @(posedge clk_sys);
    #1 chk(16'(wake_cnt - c0), 16'h0001, msg);
    chk(16'(clk_ctl.cpu_run), 16'h0001, msg);
  endtask : wake_chk

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short; the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    $display("CHECK FAILED t=%0t timeout", $time);
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {req, bus_busy, edge_cfg, rtc_run, rtc_irq, can_irq, i2c_irq, can1_en, can2_en} = '0;
    {errors, comparisons, wake_cnt} = '0;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].addr, rows[k].wdata);
      rchk(rows[k].addr, rows[k].exp, "register row");
    end
    $display("TEST registers finished");
    // Pin routing and CAN mapping; divider kept on at this clock rate
    wr(MISC_ADDR, 16'h0012);
    @(posedge clk_sys);
    can1_en <= 1'b1;
    can2_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'(pin_map.port7_sel), 16'h0001, "port remap");
    chk(16'(pin_map.can2_on_can1), 16'h0001, "parallel can");
    a = clk_ctl.can_clk_en;
    @(posedge clk_sys) can1_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'(pin_map.can2_on_can1), 16'h0000, "first can off");
    chk(16'(a ^ clk_ctl.can_clk_en), 16'h0001, "can clock halved");
    @(posedge clk_sys);
    can1_en <= 1'b1;
    can2_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'(pin_map.can2_on_can1), 16'h0000, "second can off");
    $display("TEST misc finished");
    // Idle waits for the bus, halts the CPU only, leaves on interrupt
    @(posedge clk_sys) bus_busy <= 1'b1;
    far_u.pulse(0);
    repeat (3) @(posedge clk_sys);
    rchk(STAT_ADDR, 16'h0001, "bus drain");
    @(posedge clk_sys) bus_busy <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'({clk_ctl.cpu_run, clk_ctl.periph_clk_en, clk_ctl.wdt_run}), 16'h0003, "idle");
    c0 = wake_cnt;
    far_u.lines(8'h00, 1'b1, 1'b1, 1'b1);
    wake_chk("idle exit");
    $display("TEST idle finished");
    // Protected power down: NMI gate, reset-only exit
    wr(MISC_ADDR, 16'h0008);
    @(posedge clk_sys) rtc_run <= 1'b1;
    far_u.lines(8'h00, 1'b1, 1'b1, 1'b0);
    far_u.pulse(1);
    repeat (3) @(posedge clk_sys);
    #1 chk(16'(clk_ctl.cpu_run), 16'h0001, "nmi high refuses");
    far_u.lines(8'h00, 1'b0, 1'b1, 1'b0);
    c0 = wake_cnt;
    far_u.pulse(1);
    repeat (3) @(posedge clk_sys);
    #1 chk(16'(clk_ctl), 16'h0006, "protected entry");
    far_u.lines(8'hff, 1'b1, 1'b1, 1'b1);
    #1 chk(16'(clk_ctl.cpu_run), 16'h0000, "pins ignored");
    far_u.lines(8'h00, 1'b1, 1'b0, 1'b0);
    wake_chk("reset exit");
    $display("TEST protected finished");
    // Interruptible power down: pin0 high, pin1 low, pin2 any, pin3 off
    wr(SYSCFG_ADDR, 16'h0020);
    @(posedge clk_sys);
    rtc_run  <= 1'b0;
    edge_cfg <= 16'h0039;
    far_u.lines(8'h03, 1'b1, 1'b1, 1'b0);
    far_u.pulse(1);
    repeat (3) @(posedge clk_sys);
    #1 chk(16'(clk_ctl.cpu_run), 16'h0001, "active pin refuses");
    for (int k = 0; k < 7; k++) begin
      far_u.lines(8'h0a, 1'b1, 1'b1, 1'b0);
      c0 = wake_cnt;
      far_u.pulse(1);
      repeat (3) @(posedge clk_sys);
      #1 chk(16'({clk_ctl.cpu_run, clk_ctl.osc_run}), 16'h0000, "pd entry");
      case (k)
        0: far_u.lines(8'h0b, 1'b1, 1'b1, 1'b0);
        1: far_u.lines(8'h08, 1'b1, 1'b1, 1'b0);
        2: far_u.lines(8'h0e, 1'b1, 1'b1, 1'b0);
        3: begin
          @(posedge clk_sys);
          rtc_run <= 1'b1;
          rtc_irq <= 1'b1;
        end
        4: @(posedge clk_sys) can_irq <= 1'b1;
        5: @(posedge clk_sys) i2c_irq <= 1'b1;
        default: far_u.lines(8'h0a, 1'b1, 1'b0, 1'b0);
      endcase
      repeat (4) @(posedge clk_sys);
      wake_chk("interruptible exit");
      @(posedge clk_sys);
      rtc_run <= 1'b0;
      rtc_irq <= 1'b0;
      can_irq <= 1'b0;
      i2c_irq <= 1'b0;
    end
    $display("TEST interruptible finished");
    // Lock after end of initialisation, then a mid-run reset
    far_u.pulse(2);
    wr(SYSCFG_ADDR, 16'h0000);
    rchk(SYSCFG_ADDR, 16'h0020, "config locked");
    wr(MISC_ADDR, 16'h0010);
    @(posedge clk_sys) reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1 chk(16'(pin_map.port7_sel), 16'h0000, "reset remap");
    rchk(MISC_ADDR, MISC_RST, "reset misc");
    rchk(SYSCFG_ADDR, SYSCFG_RST, "reset config");
    $display("TEST reset finished");
    final_report();
  end
endmodule : tb

`default_nettype wire
